//--- spwm_chk.sv
// Concurrent checks on the ports of the staged PWM output.
// Assumes binding into spwm_top, with mclk as its only clock.
`timescale 1ns/1ps
module spwm_chk (
   input wire mclk,
   input wire rst,
   input wire enable_relay,
   input wire enable_invert,
   input wire [2:0] select_relay,
   input wire [2:0] select_invert,
   input wire [15:0] edit_width,
   input wire [15:0] edit_period,
   input wire [3:0] active_stage,
   input wire first_regular_output,
   input wire pwm_result_terminal
);
   wire e = enable_relay ^ enable_invert;
   wire [3:0] t = active_stage;
   wire [3:0] want = {1'b0, select_relay ^ select_invert} + 4'h1;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_stage_off: assert property (!e |=> t == 4'h0)
      else $error("stage not zero while disabled");
   a_out_off: assert property (!e |=> !first_regular_output)
      else $error("output on while disabled");
   a_run_live: assert property (e |=> t != 4'h0)
      else $error("stage zero while enabled");
   a_stage_decode: assert property (e |=> t == $past(want))
      else $error("stage differs from select value");
   a_stage_range: assert property (t <= 4'h8)
      else $error("stage above eight");
   a_term_match: assert property (pwm_result_terminal == first_regular_output)
      else $error("result terminal differs from output");
   a_width_range: assert property (edit_width <= 16'h8000)
      else $error("stored width above range");
   a_period_range: assert property (!rst |=> edit_period != 16'h0000 && edit_period <= 16'h8000)
      else $error("stored period out of range");
endmodule // spwm_chk

//--- spwm_load.sv
// Load model on the PWM output terminal.
// Counts cycles driven on, and cycles neither on nor off; idle while rst is high.
`timescale 1ns/1ps
module spwm_load (
   input wire mclk,
   input wire rst,
   input wire pwm_result_terminal,
   output int on_n,
   output int bad_n
);
   always @(posedge mclk) begin
      if (!rst) begin
         if (pwm_result_terminal === 1'b1)
            on_n <= on_n + 1;
         else if (pwm_result_terminal !== 1'b0)
            bad_n <= bad_n + 1;
      end
   end
endmodule // spwm_load

//--- spwm_regs.vh
// Constants for the staged PWM output block.
// Assumes inclusion by the staged PWM design files and by its bench.
`ifndef SPWM_REGS_VH
`define SPWM_REGS_VH
`define SPWM_STAGES 8
`define SPWM_SEL_W 3
`define SPWM_STAGE_W 4
`define SPWM_MS_W 16
`define SPWM_WIDTH_MAX 16'h8000
`define SPWM_PERIOD_MIN 16'h0001
`define SPWM_PERIOD_MAX 16'h8000
`define SPWM_WIDTH_RST 16'h0000
`define SPWM_PERIOD_RST 16'h03E8
`define SPWM_MS_NS 1000000
`define SPWM_CLK_NS 20
`define SPWM_MS_CYCLES (`SPWM_MS_NS / `SPWM_CLK_NS)
`endif

//--- spwm_tick.v
// Millisecond tick generator for the staged PWM output.
// Assumes a free-running mclk at the documented rate.
`timescale 1ns/1ps
`include "spwm_regs.vh"
module spwm_tick #(
   parameter CYCLES = `SPWM_MS_CYCLES
) (
   input wire mclk,
   input wire rst,
   output reg tick_q
);
   reg [31:0] cnt_q;
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_q <= 32'h0;
         tick_q <= 1'b0;
      end else if (cnt_q >= CYCLES - 1) begin
         cnt_q <= 32'h0;
         tick_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 32'h1;
         tick_q <= 1'b0;
      end
   end
endmodule // spwm_tick

//--- spwm_top.v
// Staged PWM generator driving the first regular output terminal.
// Assumes select, enable and configuration inputs are synchronous to mclk.
`timescale 1ns/1ps
`include "spwm_regs.vh"
// Notes on behaviour
// - One PWM output on first regular output.
// - Eight configurable stages, one selectable for editing.
// - Each stage stores width and period milliseconds.
// - Report active stage, zero when disabled.
// - Select inputs come from any controller relay.
// - Active stage is one plus select value.
// - Disabled: output off, stage zero, selects ignored.
module spwm_top #(
   parameter MS_CYCLES = `SPWM_MS_CYCLES
) (
   input wire mclk,
   input wire rst,
   input wire enable_relay,
   input wire enable_invert,
   input wire [2:0] select_relay,
   input wire [2:0] select_invert,
   input wire [2:0] edit_stage,
   input wire cfg_write,
   input wire [15:0] cfg_width,
   input wire [15:0] cfg_period,
   output reg [15:0] edit_width,
   output reg [15:0] edit_period,
   output reg [3:0] active_stage,
   output reg first_regular_output,
   output wire pwm_result_terminal
);
   localparam STAGES = `SPWM_STAGES;
   localparam SEL_W = `SPWM_SEL_W;
   localparam STAGE_W = `SPWM_STAGE_W;
   localparam MS_W = `SPWM_MS_W;
   localparam [15:0] WIDTH_MIN = 16'h0000;

   // Stage tables, one pulse width and one period for each stage.
   reg [MS_W-1:0] width_mem [0:STAGES-1];
   reg [MS_W-1:0] period_mem [0:STAGES-1];

   // Millisecond count within the period, and the stage it belongs to.
   reg [MS_W-1:0] ms_q;
   reg [MS_W-1:0] ms_d;
   reg [STAGE_W-1:0] stage_q;
   reg [STAGE_W-1:0] stage_d;
   reg out_d;

   // Clipped settings for the table write.
   reg [MS_W-1:0] width_in;
   reg [MS_W-1:0] period_in;

   wire tick;
   wire en;
   wire [SEL_W-1:0] sel;
   wire [STAGE_W-1:0] sel_stage;
   wire [MS_W-1:0] cur_w;
   wire [MS_W-1:0] cur_p;
   wire [MS_W-1:0] edit_width_d;
   wire [MS_W-1:0] edit_period_d;
   wire stage_moved;
   wire period_end;
   wire full_on;
   integer i;

   // Applies the normal or the inverted form of a relay source.
   function relay_level;
      input state;
      input invert;
      begin
         relay_level = state ^ invert;
      end
   endfunction

   // Turns a three-bit select value into a stage number from one to eight.
   function [3:0] stage_of;
      input [2:0] s;
      begin
         stage_of = {1'b0, s} + 4'h1;
      end
   endfunction

   // Limits a setting to the range from lo to hi.
   function [15:0] clip;
      input [15:0] v;
      input [15:0] lo;
      input [15:0] hi;
      begin
         clip = (v < lo) ? lo : ((v > hi) ? hi : v);
      end
   endfunction

   // Tells whether the next millisecond step reaches the end of the period.
   function last_ms;
      input [15:0] count;
      input [15:0] period;
      begin
         last_ms = (({1'b0, count} + 17'h00001) >= {1'b0, period});
      end
   endfunction

   spwm_tick #(
      .CYCLES(MS_CYCLES)
   ) spwm_tick_i (
      .mclk(mclk),
      .rst(rst),
      .tick_q(tick)
   );

   // Each source is a relay state, optionally complemented.
   assign en = relay_level(enable_relay, enable_invert);
   assign sel[2] = relay_level(select_relay[2], select_invert[2]);
   assign sel[1] = relay_level(select_relay[1], select_invert[1]);
   assign sel[0] = relay_level(select_relay[0], select_invert[0]);
   assign sel_stage = stage_of(sel);

   // Settings of the stage now selected.
   assign cur_w = width_mem[sel];
   assign cur_p = period_mem[sel];
   assign stage_moved = (stage_q != sel_stage);
   assign period_end = last_ms(ms_q, cur_p);
   assign full_on = (cur_w >= cur_p);

   // Settings of the stage being edited.
   assign edit_width_d = width_mem[edit_stage];
   assign edit_period_d = period_mem[edit_stage];

   // The result terminal is the first regular output itself.
   assign pwm_result_terminal = first_regular_output;

   // Clips incoming settings to their legal ranges.
   always @* begin
      width_in = clip(cfg_width, WIDTH_MIN, `SPWM_WIDTH_MAX);
      period_in = clip(cfg_period, `SPWM_PERIOD_MIN, `SPWM_PERIOD_MAX);
   end

   // Stage table write; back-to-back writes are taken.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (i = 0; i < STAGES; i = i + 1) begin
            width_mem[i] <= `SPWM_WIDTH_RST;
            period_mem[i] <= `SPWM_PERIOD_RST;
         end
      end else if (cfg_write) begin
         width_mem[edit_stage] <= width_in;
         period_mem[edit_stage] <= period_in;
      end
   end

   // Edit readback, one cycle behind the table.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         edit_width <= 16'h0000;
         edit_period <= 16'h0000;
      end else begin
         edit_width <= edit_width_d;
         edit_period <= edit_period_d;
      end
   end

   // Next stage is zero while disabled, else one plus the select value.
   always @* begin
      if (en) begin
         stage_d = sel_stage;
      end else begin
         stage_d = 4'h0;
      end
   end

   // Stage registers; the reported stage follows the next stage.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         stage_q <= 4'h0;
         active_stage <= 4'h0;
      end else begin
         stage_q <= stage_d;
         active_stage <= stage_d;
      end
   end

   // Next millisecond count; a new stage restarts its period.
   always @* begin
      ms_d = ms_q;
      if (!en) begin
         ms_d = 16'h0000;
      end else if (stage_moved) begin
         ms_d = 16'h0000;
      end else if (tick) begin
         if (period_end) begin
            ms_d = 16'h0000;
         end else begin
            ms_d = ms_q + 16'h0001;
         end
      end
   end

   // Next output level for the millisecond now counted.
   always @* begin
      if (!en) begin
         out_d = 1'b0;
      end else if (full_on) begin
         out_d = 1'b1;
      end else begin
         out_d = (ms_q < cur_w);
      end
   end

   // Millisecond count register.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         ms_q <= 16'h0000;
      end else begin
         ms_q <= ms_d;
      end
   end

   // Output register; the waveform leaves through a flip-flop only.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         first_regular_output <= 1'b0;
      end else begin
         first_regular_output <= out_d;
      end
   end
endmodule // spwm_top

//--- spwm_top_tb.sv
// Bench for spwm_top: stage tables, stage decode, waveform counts and reset.
// Assumes the load model on the result terminal and the checker bound into spwm_top.
`timescale 1ns/1ps
`include "spwm_regs.vh"
`define CHK(name, want, seen) begin compares++; if ((seen) !== (want)) begin num_errors++; \
$display("mismatch %s %0d %0d", name, want, seen); end end
module spwm_top_tb;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic enable_relay = 1'b0;
   logic enable_invert = 1'b0;
   logic cfg_write = 1'b0;
   logic [2:0] select_relay = 3'h0;
   logic [2:0] select_invert = 3'h0;
   logic [2:0] edit_stage = 3'h0;
   logic [15:0] cfg_width = 16'h0000;
   logic [15:0] cfg_period = 16'h0000;
   wire [15:0] edit_width;
   wire [15:0] edit_period;
   wire [3:0] active_stage;
   wire first_regular_output;
   wire pwm_result_terminal;
   int num_errors = 0;
   int compares = 0;
   int on_n;
   int bad_n;
   int c;
   always #10 mclk = ~mclk;
   spwm_top #(
      .MS_CYCLES(4)
   ) spwm_top_i (
      .mclk(mclk),
      .rst(rst),
      .enable_relay(enable_relay),
      .enable_invert(enable_invert),
      .select_relay(select_relay),
      .select_invert(select_invert),
      .edit_stage(edit_stage),
      .cfg_write(cfg_write),
      .cfg_width(cfg_width),
      .cfg_period(cfg_period),
      .edit_width(edit_width),
      .edit_period(edit_period),
      .active_stage(active_stage),
      .first_regular_output(first_regular_output),
      .pwm_result_terminal(pwm_result_terminal)
   );
   spwm_load spwm_load_i (
      .mclk(mclk),
      .rst(rst),
      .pwm_result_terminal(pwm_result_terminal),
      .on_n(on_n),
      .bad_n(bad_n)
   );
   task cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task wr(input logic [2:0] s, input logic [15:0] w, input logic [15:0] p);
      edit_stage = s;
      cfg_width = w;
      cfg_period = p;
      cfg_write = 1'b1;
      cyc(1);
      cfg_write = 1'b0;
      cyc(1);
   endtask
   task run(input logic e, input logic [2:0] s, input int t, input int n);
      enable_relay = e;
      select_relay = s;
      cyc(16);
      c = on_n;
      cyc(24);
      `CHK("stage", t, active_stage)
      `CHK("on count", n, on_n - c)
      `CHK("terminal", first_regular_output, pwm_result_terminal)
      `CHK("unknown", 0, bad_n)
   endtask
   task stop_test;
      $display("errors %0d of %0d compares", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      cyc(20);
      rst = 1'b0;
      wr(3'h1, 16'h0002, 16'h0003);
      `CHK("edit width", 16'h0002, edit_width)
      `CHK("edit period", 16'h0003, edit_period)
      wr(3'h2, 16'hFFFF, 16'h0000);
      `CHK("clipped width", `SPWM_WIDTH_MAX, edit_width)
      `CHK("clipped period", `SPWM_PERIOD_MIN, edit_period)
      for (int i = 0; i < 8; i++) begin
         run(1'b1, i[2:0], i + 1, (i == 1) ? 16 : ((i == 2) ? 24 : 0));
      end
      enable_invert = 1'b1;
      select_invert = 3'h7;
      run(1'b1, 3'h0, 0, 0);
      run(1'b0, 3'h5, 3, 24);
      enable_invert = 1'b0;
      select_invert = 3'h0;
      rst = 1'b1;
      cyc(2);
      `CHK("reset stage", 0, active_stage)
      `CHK("reset output", 0, pwm_result_terminal)
      rst = 1'b0;
      cyc(2);
      `CHK("reset period", `SPWM_PERIOD_RST, edit_period)
      `CHK("reset width", `SPWM_WIDTH_RST, edit_width)
      run(1'b1, 3'h2, 3, 0);
      stop_test;
   end
endmodule // spwm_top_tb
bind spwm_top spwm_chk spwm_chk_i (
   .mclk(mclk),
   .rst(rst),
   .enable_relay(enable_relay),
   .enable_invert(enable_invert),
   .select_relay(select_relay),
   .select_invert(select_invert),
   .edit_width(edit_width),
   .edit_period(edit_period),
   .active_stage(active_stage),
   .first_regular_output(first_regular_output),
   .pwm_result_terminal(pwm_result_terminal)
);
